// ### hw/wcas_pkg.sv
//Contract
//- a prescaler divides the crystal input down to a once-per-second tick that advances time.
//- seconds and minutes each count sixty values as the two lowest time stages.
//- hours count twenty-four values and days count 32768 values as the upper stages.
//- periodic interrupts, when enabled, are raised on every second, minute, hour and day tick.
//- an enabled alarm interrupts when the running time equals its programmed value.
//- the first alarm matches hours, minutes and seconds only, once each day.
//- the second alarm matches day, hours, minutes and seconds.
//- the stopwatch loads a programmed value and drops by one on every tick.
//- an enabled stopwatch underflowing past zero raises the stopwatch interrupt.
//- any enabled clock interrupt condition is also a wakeup event from sleep.
//- a clock wakeup event can also wake from deep sleep and leave hibernate.
//- timekeeping runs from the crystal, independent of the processor's low-power state.
package wcas_pkg;

    typedef struct packed {
        logic [14:0] day;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } wcas_time_s;

    localparam logic [7:0] OFF_TIME = 8'h00;
    localparam logic [7:0] OFF_ALARM_TOD = 8'h04;
    localparam logic [7:0] OFF_ALARM_DAY = 8'h08;
    localparam logic [7:0] OFF_SWATCH = 8'h0c;
    localparam logic [7:0] OFF_INT_EN = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_WAKE_CFG = 8'h18;

    localparam logic [5:0] SEC_LAST = 6'h3b;
    localparam logic [5:0] MIN_LAST = 6'h3b;
    localparam logic [4:0] HOUR_LAST = 5'h17;

    localparam int CRYSTAL_HZ = 32768;
    localparam int TICK_HZ = 1;
    localparam int PRESCALE_DEFAULT = CRYSTAL_HZ / TICK_HZ;

    localparam int NUM_EV = 7;
    localparam int EV_SEC = 0;
    localparam int EV_MIN = 1;
    localparam int EV_HOUR = 2;
    localparam int EV_DAY = 3;
    localparam int EV_ALM_TOD = 4;
    localparam int EV_ALM_DAY = 5;
    localparam int EV_SWATCH = 6;

    localparam int WAKE_DEEP_BIT = 0;
    localparam int WAKE_HIB_BIT = 1;

    localparam logic [NUM_EV-1:0] INT_EN_RST = 7'h00;
    localparam logic [1:0] WAKE_CFG_RST = 2'h0;
    localparam logic [31:0] TIME_RST = 32'h0000_0000;

endpackage

// ### hw/wcas_top.sv
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module wcas_top #(
    parameter int PRESCALE_DIV = wcas_pkg::PRESCALE_DEFAULT,
    parameter int SW_WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic crystal_input,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq_out,
    output logic wake_sleep,
    output logic wake_deep,
    output logic wake_hib
);
    localparam int PW = $clog2(PRESCALE_DIV);
    localparam int NE = wcas_pkg::NUM_EV;

    if (PRESCALE_DIV < 2) begin : g_chk_div
        $error("PRESCALE_DIV must be at least 2");
    end
    if (SW_WIDTH < 1 || SW_WIDTH > 32) begin : g_chk_sw
        $error("SW_WIDTH must be 1 to 32");
    end

    function automatic logic addr_hit(input logic [7:0] a);
        if (a == wcas_pkg::OFF_TIME) begin
            addr_hit = 1'b1;
        end else if (a == wcas_pkg::OFF_ALARM_TOD || a == wcas_pkg::OFF_ALARM_DAY) begin
            addr_hit = 1'b1;
        end else if (a == wcas_pkg::OFF_SWATCH || a == wcas_pkg::OFF_INT_EN) begin
            addr_hit = 1'b1;
        end else if (a == wcas_pkg::OFF_STATUS || a == wcas_pkg::OFF_WAKE_CFG) begin
            addr_hit = 1'b1;
        end else begin
            addr_hit = 1'b0;
        end
    endfunction

    logic xtal_prev_reg, xtal_prev_next;
    logic [PW-1:0] presc_reg, presc_next;
    wcas_pkg::wcas_time_s time_reg, time_next, t_adv;
    wcas_pkg::wcas_time_s alarm_tod_reg, alarm_tod_next;
    wcas_pkg::wcas_time_s alarm_day_reg, alarm_day_next;
    logic [SW_WIDTH-1:0] sw_reg, sw_next;
    logic [NE-1:0] int_en_reg, int_en_next;
    logic [NE-1:0] status_reg, status_next;
    logic [1:0] wake_cfg_reg, wake_cfg_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;
    logic wake_sleep_reg, wake_sleep_next;
    logic wake_deep_reg, wake_deep_next;
    logic wake_hib_reg, wake_hib_next;

    logic xtal_edge, tick, acc, wr, setup;
    logic wr_time, wr_sw;
    logic sec_wrap, min_wrap, hour_wrap;
    logic [NE-1:0] ev, clr;
    logic wake_ev;

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq_out = irq_reg;
    assign wake_sleep = wake_sleep_reg;
    assign wake_deep = wake_deep_reg;
    assign wake_hib = wake_hib_reg;

    always_comb begin
        // answer one cycle into the access phase, so read data is registered
        setup = psel && penable && !pready_reg;
        acc = psel && penable && pready_reg;
        wr = acc && pwrite;
        wr_time = wr && paddr == wcas_pkg::OFF_TIME;
        wr_sw = wr && paddr == wcas_pkg::OFF_SWATCH;

        // counting only needs crystal edges, never the processor's clock gating
        xtal_prev_next = crystal_input;
        xtal_edge = crystal_input && !xtal_prev_reg;
        tick = xtal_edge && presc_reg == PW'(PRESCALE_DIV - 1);
        presc_next = presc_reg;
        if (xtal_edge) begin
            presc_next = tick ? '0 : presc_reg + PW'(1);
        end

        sec_wrap = time_reg.sec == wcas_pkg::SEC_LAST;
        min_wrap = time_reg.min == wcas_pkg::MIN_LAST;
        hour_wrap = time_reg.hour == wcas_pkg::HOUR_LAST;
        t_adv = time_reg;
        t_adv.sec = sec_wrap ? 6'h00 : time_reg.sec + 6'h01;
        if (sec_wrap) begin
            t_adv.min = min_wrap ? 6'h00 : time_reg.min + 6'h01;
        end
        if (sec_wrap && min_wrap) begin
            t_adv.hour = hour_wrap ? 5'h00 : time_reg.hour + 5'h01;
        end
        if (sec_wrap && min_wrap && hour_wrap) begin
            t_adv.day = time_reg.day + 15'h0001;
        end

        ev = '0;
        ev[wcas_pkg::EV_SEC] = tick;
        ev[wcas_pkg::EV_MIN] = tick && sec_wrap;
        ev[wcas_pkg::EV_HOUR] = tick && sec_wrap && min_wrap;
        ev[wcas_pkg::EV_DAY] = tick && sec_wrap && min_wrap && hour_wrap;
        ev[wcas_pkg::EV_ALM_TOD] = tick && t_adv[16:0] == alarm_tod_reg[16:0];
        ev[wcas_pkg::EV_ALM_DAY] = tick && t_adv == alarm_day_reg;
        ev[wcas_pkg::EV_SWATCH] = tick && sw_reg == '0
            && int_en_reg[wcas_pkg::EV_SWATCH];

        time_next = tick ? t_adv : time_reg;
        sw_next = tick ? sw_reg - SW_WIDTH'(1) : sw_reg;
        alarm_tod_next = alarm_tod_reg;
        alarm_day_next = alarm_day_reg;
        int_en_next = int_en_reg;
        wake_cfg_next = wake_cfg_reg;
        clr = '0;
        // a software write to time or stopwatch beats a tick landing in the same cycle
        if (wr_time) begin
            time_next = pwdata;
        end else if (wr_sw) begin
            sw_next = pwdata[SW_WIDTH-1:0];
        end else if (wr && paddr == wcas_pkg::OFF_ALARM_TOD) begin
            alarm_tod_next = pwdata;
        end else if (wr && paddr == wcas_pkg::OFF_ALARM_DAY) begin
            alarm_day_next = pwdata;
        end else if (wr && paddr == wcas_pkg::OFF_INT_EN) begin
            int_en_next = pwdata[NE-1:0];
        end else if (wr && paddr == wcas_pkg::OFF_STATUS) begin
            clr = pwdata[NE-1:0];
        end else if (wr && paddr == wcas_pkg::OFF_WAKE_CFG) begin
            wake_cfg_next = pwdata[1:0];
        end

        // set wins over a write-one-to-clear in the same cycle
        status_next = (status_reg & ~clr) | ev;
        // alarms interrupt only through their enable
        irq_next = |(status_next & int_en_next);
        wake_ev = |(ev & int_en_reg);
        wake_sleep_next = wake_ev;
        wake_deep_next = wake_ev && wake_cfg_reg[wcas_pkg::WAKE_DEEP_BIT];
        wake_hib_next = wake_ev && wake_cfg_reg[wcas_pkg::WAKE_HIB_BIT];

        pready_next = setup;
        pslverr_next = setup && !addr_hit(paddr);
        prdata_next = prdata_reg;
        if (setup && !pwrite) begin
            if (paddr == wcas_pkg::OFF_TIME) begin
                prdata_next = time_reg;
            end else if (paddr == wcas_pkg::OFF_ALARM_TOD) begin
                prdata_next = alarm_tod_reg;
            end else if (paddr == wcas_pkg::OFF_ALARM_DAY) begin
                prdata_next = alarm_day_reg;
            end else if (paddr == wcas_pkg::OFF_SWATCH) begin
                prdata_next = 32'(sw_reg);
            end else if (paddr == wcas_pkg::OFF_INT_EN) begin
                prdata_next = 32'(int_en_reg);
            end else if (paddr == wcas_pkg::OFF_STATUS) begin
                prdata_next = 32'(status_reg);
            end else if (paddr == wcas_pkg::OFF_WAKE_CFG) begin
                prdata_next = 32'(wake_cfg_reg);
            end else begin
                prdata_next = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            xtal_prev_reg <= 1'b0;
            presc_reg <= '0;
            time_reg <= wcas_pkg::TIME_RST;
            alarm_tod_reg <= wcas_pkg::TIME_RST;
            alarm_day_reg <= wcas_pkg::TIME_RST;
            sw_reg <= '0;
            int_en_reg <= wcas_pkg::INT_EN_RST;
            status_reg <= '0;
            wake_cfg_reg <= wcas_pkg::WAKE_CFG_RST;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            wake_sleep_reg <= 1'b0;
            wake_deep_reg <= 1'b0;
            wake_hib_reg <= 1'b0;
        end else begin
            xtal_prev_reg <= xtal_prev_next;
            presc_reg <= presc_next;
            time_reg <= time_next;
            alarm_tod_reg <= alarm_tod_next;
            alarm_day_reg <= alarm_day_next;
            sw_reg <= sw_next;
            int_en_reg <= int_en_next;
            status_reg <= status_next;
            wake_cfg_reg <= wake_cfg_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            wake_sleep_reg <= wake_sleep_next;
            wake_deep_reg <= wake_deep_next;
            wake_hib_reg <= wake_hib_next;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence last_sec_s;
        tick && !wr_time && time_reg.sec == wcas_pkg::SEC_LAST;
    endsequence

    sequence last_hour_s;
        last_sec_s ##0 time_reg.min == wcas_pkg::MIN_LAST
            && time_reg.hour == wcas_pkg::HOUR_LAST;
    endsequence

    sequence last_min_s;
        last_sec_s ##0 time_reg.min == wcas_pkg::MIN_LAST;
    endsequence

    tick_restart_a: assert property (tick |=> presc_reg == '0)
        else $error("prescaler did not restart after tick");
    sec_wrap_a: assert property (last_sec_s |=> time_reg.sec == 6'h00)
        else $error("seconds did not wrap to zero");
    hour_wrap_a: assert property (last_hour_s |=> time_reg.hour == 5'h00
        && time_reg.day == $past(time_reg.day) + 15'h0001)
        else $error("hour wrap did not carry into day");
    min_carry_a: assert property (last_sec_s ##0 time_reg.min != wcas_pkg::MIN_LAST
        |=> time_reg.min == $past(time_reg.min) + 6'h01)
        else $error("minute did not take the seconds carry");
    sec_event_a: assert property (tick |=> status_reg[wcas_pkg::EV_SEC])
        else $error("second flag not set on tick");
    day_alarm_a: assert property ($rose(status_reg[wcas_pkg::EV_ALM_DAY])
        && !$past(wr_time) |-> time_reg == $past(alarm_day_reg))
        else $error("day alarm fired off its programmed time");
    swatch_dec_a: assert property (tick && !wr_sw |=> sw_reg == $past(sw_reg) - 1'b1)
        else $error("stopwatch did not count down");
    swatch_under_a: assert property (tick && sw_reg == '0
        && int_en_reg[wcas_pkg::EV_SWATCH] |=> status_reg[wcas_pkg::EV_SWATCH])
        else $error("stopwatch underflow not flagged");
    irq_pending_a: assert property (irq_out == |(status_reg & int_en_reg))
        else $error("interrupt does not follow enabled flags");
    wake_cause_a: assert property (wake_sleep |-> $past(|(ev & int_en_reg)))
        else $error("wakeup without enabled event");
    wake_deep_a: assert property (wake_deep |-> wake_sleep
        && $past(wake_cfg_reg[wcas_pkg::WAKE_DEEP_BIT]))
        else $error("deep wakeup not gated by its enable");

    presc_hold_a: assert property (!xtal_edge |=> $stable(presc_reg))
        else $error("prescaler moved without a crystal edge");
    presc_step_a: assert property (xtal_edge && !tick
        |=> presc_reg == $past(presc_reg) + 1'b1)
        else $error("prescaler missed a crystal edge");
    time_hold_a: assert property (!tick && !wr_time |=> $stable(time_reg))
        else $error("time changed between ticks");
    sec_step_a: assert property (tick && !wr_time && !sec_wrap
        |=> time_reg.sec == $past(time_reg.sec) + 6'h01)
        else $error("seconds did not count up on tick");
    min_wrap_a: assert property (last_min_s |=> time_reg.min == 6'h00)
        else $error("minutes did not wrap to zero");
    hour_carry_a: assert property (last_min_s ##0 time_reg.hour != wcas_pkg::HOUR_LAST
        |=> time_reg.hour == $past(time_reg.hour) + 5'h01)
        else $error("hour did not take the minutes carry");
    min_event_a: assert property (last_sec_s |=> status_reg[wcas_pkg::EV_MIN])
        else $error("minute flag not set on minute tick");
    hour_event_a: assert property (last_min_s |=> status_reg[wcas_pkg::EV_HOUR])
        else $error("hour flag not set on hour tick");
    day_event_a: assert property (last_hour_s |=> status_reg[wcas_pkg::EV_DAY])
        else $error("day flag not set on day tick");
    alarm_tick_a: assert property ($rose(status_reg[wcas_pkg::EV_ALM_TOD])
        |-> $past(tick))
        else $error("alarm flag rose off a tick");
    tod_alarm_a: assert property ($rose(status_reg[wcas_pkg::EV_ALM_TOD])
        && !$past(wr_time) |-> time_reg[16:0] == $past(alarm_tod_reg[16:0]))
        else $error("time of day alarm fired off its programmed time");
    swatch_load_a: assert property (wr_sw |=> sw_reg == $past(pwdata[SW_WIDTH-1:0]))
        else $error("stopwatch did not load the written value");
    swatch_gate_a: assert property ($rose(status_reg[wcas_pkg::EV_SWATCH])
        |-> $past(int_en_reg[wcas_pkg::EV_SWATCH]))
        else $error("stopwatch flagged while disabled");
    wake_fire_a: assert property (|(ev & int_en_reg) |=> wake_sleep)
        else $error("enabled event gave no wakeup");
    wake_tick_a: assert property (wake_sleep |-> $past(tick))
        else $error("wakeup off a tick");
    wake_hib_a: assert property (wake_hib |-> wake_sleep
        && $past(wake_cfg_reg[wcas_pkg::WAKE_HIB_BIT]))
        else $error("hibernate wakeup not gated by its enable");
    flag_sticky_a: assert property (!wr
        |=> (status_reg & $past(status_reg)) == $past(status_reg))
        else $error("status flag dropped without a clear");
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int DIV = 4;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic crystal_input = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq_out, wake_sleep, wake_deep, wake_hib;
    int fails = 0;
    int cmp_count = 0;
    int day = 0, hr = 0, mn = 0, sc = 0, sw = 0, stat = 0, ien = 0, wcfg = 0;
    int n_sl = 0, n_dp = 0, n_hb = 0, g_sl = 0, g_dp = 0, g_hb = 0;
    logic [31:0] atod = 32'h0;
    logic [31:0] aday = 32'h0;
    logic [31:0] rd;
    logic er;
    logic [15:0] rnd = 16'hb40f;

    wcas_top #(.PRESCALE_DIV(DIV), .SW_WIDTH(16)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .crystal_input(crystal_input), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_out(irq_out), .wake_sleep(wake_sleep), .wake_deep(wake_deep), .wake_hib(wake_hib));

    always #2.5 sys_clk = ~sys_clk;

    // pulses are one cycle wide, so counting them catches doubles and misses
    always @(posedge sys_clk) begin
        if (wake_sleep === 1'b1) g_sl++;
        if (wake_deep === 1'b1) g_dp++;
        if (wake_hib === 1'b1) g_hb++;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic logic [31:0] tw();
        return {day[14:0], hr[4:0], mn[5:0], sc[5:0]};
    endfunction

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        case (a)
            wcas_pkg::OFF_TIME: begin
                day = d[31:17];
                hr = d[16:12];
                mn = d[11:6];
                sc = d[5:0];
            end
            wcas_pkg::OFF_ALARM_TOD: atod = d;
            wcas_pkg::OFF_ALARM_DAY: aday = d;
            wcas_pkg::OFF_SWATCH: sw = d[15:0];
            wcas_pkg::OFF_INT_EN: ien = d[6:0];
            wcas_pkg::OFF_STATUS: stat = stat & ~int'(d[6:0]);
            wcas_pkg::OFF_WAKE_CFG: wcfg = d[1:0];
            default: ;
        endcase
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic tick(input int n);
        int ev;
        logic [31:0] t;
        repeat (n) begin
            repeat (DIV) begin
                @(posedge sys_clk);
                crystal_input <= 1'b1;
                repeat (3) @(posedge sys_clk);
                crystal_input <= 1'b0;
                repeat (3) @(posedge sys_clk);
            end
            repeat (6) @(posedge sys_clk);
            ev = 1;
            sc++;
            if (sc == 60) begin
                sc = 0;
                mn++;
                ev |= 2;
                if (mn == 60) begin
                    mn = 0;
                    hr++;
                    ev |= 4;
                    if (hr == 24) begin
                        hr = 0;
                        day = (day + 1) % 32768;
                        ev |= 8;
                    end
                end
            end
            t = tw();
            if (t[16:0] == atod[16:0]) ev |= 16;
            if (t == aday) ev |= 32;
            if (ien[6] && sw == 0) ev |= 64;
            sw = (sw - 1) & 16'hffff;
            stat |= ev;
            if ((ev & ien) != 0) begin
                n_sl++;
                if (wcfg[0]) n_dp++;
                if (wcfg[1]) n_hb++;
            end
            rchk(wcas_pkg::OFF_TIME, tw());
            rchk(wcas_pkg::OFF_STATUS, stat);
            chk({31'h0, irq_out}, {31'h0, (stat & ien) != 0});
        end
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a <= 8'h18; a += 4) rchk(a[7:0], 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("test reset done");
        // day counter at its top value, two seconds before midnight
        wreg(wcas_pkg::OFF_INT_EN, 32'h0f);
        wreg(wcas_pkg::OFF_WAKE_CFG, 32'h3);
        wreg(wcas_pkg::OFF_TIME, {15'h7fff, 5'h17, 6'h3b, 6'h3a});
        tick(2);
        wreg(wcas_pkg::OFF_STATUS, 32'h7f);
        rchk(wcas_pkg::OFF_STATUS, 32'h0);
        chk({31'h0, irq_out}, 32'h0);
        $display("test wrap done");
        rnd = lfsr(rnd);
        wreg(wcas_pkg::OFF_ALARM_TOD, {rnd[14:0], 17'h2});
        wreg(wcas_pkg::OFF_ALARM_DAY, 32'h3);
        wreg(wcas_pkg::OFF_INT_EN, 32'h30);
        wreg(wcas_pkg::OFF_WAKE_CFG, 32'h1);
        tick(4);
        rnd = lfsr(rnd);
        wreg(wcas_pkg::OFF_ALARM_TOD, {rnd[14:0], 17'h5});
        wreg(wcas_pkg::OFF_ALARM_DAY, {15'h1, 17'h5});
        tick(2);
        $display("test alarm done");
        rnd = lfsr(rnd);
        wreg(wcas_pkg::OFF_STATUS, 32'h7f);
        wreg(wcas_pkg::OFF_INT_EN, 32'h40);
        wreg(wcas_pkg::OFF_WAKE_CFG, 32'h2);
        wreg(wcas_pkg::OFF_SWATCH, {30'h0, rnd[1:0]});
        tick(int'(rnd[1:0]) + 2);
        rchk(wcas_pkg::OFF_SWATCH, sw);
        $display("test stopwatch done");
        chk(g_sl, n_sl);
        chk(g_dp, n_dp);
        chk(g_hb, n_hb);
        $display("test wake done");
        results();
    end
endmodule
`default_nettype wire
